// ---- rtl/vcodiv_pkg.sv ----
// Package: register map, fields and divider ratios of the oscillator control block
`default_nettype none
package vcodiv_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int unsigned ADDR_W = 12;                 // Register address width
    localparam logic [11:0] OSC_CTRL_ADDR = 12'h0F3;     // Oscillator control
    localparam logic [11:0] OSC_DIV_ADDR = 12'h0F4;      // Oscillator divider control
    localparam logic [7:0] OSC_CTRL_RESET = 8'h00;       // All control bits at default 0
    localparam logic [7:0] OSC_DIV_RESET = 8'h00;        // Divide-by-3, both running
    localparam logic [7:0] OSC_CTRL_MASK = 8'h1E;        // Writable bits [4:1]
    localparam logic [7:0] OSC_DIV_MASK = 8'h77;         // Writable bits 6..4 and 2..0
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;        // Read value off the map
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int unsigned SYNC_OVR_BIT = 4;            // Force sync release
    localparam int unsigned REF_OVR_BIT = 3;             // Force reference valid
    localparam int unsigned MIDSCALE_BIT = 2;            // Force midscale control voltage
    localparam int unsigned CAL_BIT = 1;                 // Calibrate oscillator
    localparam int unsigned DIV2_PD_BIT = 6;             // Second divider power-down
    localparam int unsigned DIV2_LSB = 4;                // Second divider ratio field
    localparam int unsigned DIV1_PD_BIT = 2;             // First divider power-down
    localparam int unsigned DIV1_LSB = 0;                // First divider ratio field
    // ----------------------------------------
    // Divider ratio codes and values
    // ----------------------------------------
    localparam logic [1:0] DIVSEL_3 = 2'h0;              // Divide by 3
    localparam logic [1:0] DIVSEL_4 = 2'h1;              // Divide by 4
    localparam logic [1:0] DIVSEL_5 = 2'h2;              // Divide by 5
    localparam logic [1:0] DIVSEL_3_ALT = 2'h3;          // Divide by 3, second code
    localparam logic [2:0] RATIO_3 = 3'h3;               // Ratio three
    localparam logic [2:0] RATIO_4 = 3'h4;               // Ratio four
    localparam logic [2:0] RATIO_5 = 3'h5;               // Ratio five
    // Distribution sync state
    typedef enum logic [0:0] {VCODIV_HELD, VCODIV_RELEASED} vcodiv_sync_e;
endpackage : vcodiv_pkg
`default_nettype wire

// ---- rtl/vcodiv_top.sv ----
// Oscillator control and oscillator divider selection registers with sync release
//
// Behaviour
// - Override clear: hold distribution until lock
// - On lock, release all dividers together
// - Override set: release immediately, ignore lock
// - Override clear: reference valid from input_pll
// - Override set: reference always treated valid
// - Midscale bit forces oscillator control midscale
// - Writing calibrate starts calibration, never self-clears
// - Calibrate bit zero holds calibration reset
// - Power-down bit stops its oscillator divider
// - Second divider ratio 3/4/5/3, channels 4-9
// - First divider ratio 3/4/5/3, all channels
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module vcodiv_top
    import vcodiv_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Status from neighbouring blocks
    input wire logic i_output_pll_lock,
    input wire logic i_input_pll_osc_valid,
    // Distribution and oscillator controls
    output logic o_dist_sync_hold,
    output logic o_dist_sync_release,
    output logic o_output_pll_ref_valid,
    output logic o_osc_midscale,
    output logic o_osc_cal_run,
    output logic o_osc_cal_reset,
    // First oscillator divider (all channels)
    output logic o_first_osc_divider_pd,
    output logic [2:0] o_first_osc_divider_ratio,
    // Second oscillator divider (channels 4 to 9)
    output logic o_second_osc_divider_pd,
    output logic [2:0] o_second_osc_divider_ratio
);

    // ----------------------------------------
    // Operating notes
    // ----------------------------------------
    // Both registers reset to zero: distribution held, tuning normal,
    // calibration held in reset and both dividers dividing by three.
    // The sync state reacts one edge after lock or override is seen, so
    // the start pulse and the falling hold level share one cycle and
    // every channel divider sees the same start edge.
    // Losing lock with the override clear drops back into hold, which
    // keeps the outputs static while the output loop locks again.
    // The calibrate bit is a plain level: hardware never clears it, so a
    // second calibration needs a write of zero and then one of one.
    // The reference-valid output passes the indicator through unregistered,
    // so the output loop sees a change in the same cycle.
    // Reserved bits are masked on write and always read as zero.
    // Read data stand for one cycle only and are zero otherwise.

    // ----------------------------------------
    // Ratio decode function
    // ----------------------------------------
    // Codes 00 and 11 both give divide by three
    function automatic logic [2:0] ratio_of(input logic [1:0] code);
        logic [2:0] r;
        r = RATIO_3;
        unique case (code)
            DIVSEL_4: begin
                r = RATIO_4;
            end
            DIVSEL_5: begin
                r = RATIO_5;
            end
            default: begin
                r = RATIO_3; // Codes 00 and 11
            end
        endcase
        return r;
    endfunction : ratio_of

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] ctrl_q; // Oscillator control
    logic [7:0] div_q; // Divider control
    logic [7:0] rdata_q; // Read data
    vcodiv_sync_e sync_q; // Distribution sync state
    vcodiv_sync_e sync_d; // Next sync state

    // Address decode
    wire logic hit_ctrl = (i_addr == OSC_CTRL_ADDR);
    wire logic hit_div = (i_addr == OSC_DIV_ADDR);
    wire logic [7:0] rd_mux = hit_ctrl ? ctrl_q : (hit_div ? div_q : UNMAPPED_DATA);

    // Write strobes qualified by address
    wire logic wr_ctrl = i_wr && hit_ctrl; // Write to oscillator control
    wire logic wr_div = i_wr && hit_div; // Write to divider control

    // Field views
    wire logic sync_ovr = ctrl_q[SYNC_OVR_BIT];
    wire logic ref_ovr = ctrl_q[REF_OVR_BIT];
    wire logic cal_bit = ctrl_q[CAL_BIT];

    // Register writes; only software changes the calibrate bit
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= OSC_CTRL_RESET;
            div_q <= OSC_DIV_RESET;
        end else begin
            // Control write; reserved bits stay zero
            if (wr_ctrl) begin
                ctrl_q <= i_wdata & OSC_CTRL_MASK;
            end
            // Divider write; reserved bits stay zero
            if (wr_div) begin
                div_q <= i_wdata & OSC_DIV_MASK;
            end
        end
    end

    // Read data one cycle after strobe
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= UNMAPPED_DATA;
        end else if (i_rd) begin
            // Selected register on a read strobe
            rdata_q <= rd_mux;
        end else begin
            // Zero in every other cycle
            rdata_q <= UNMAPPED_DATA;
        end
    end
    assign o_rdata = rdata_q;

    // ----------------------------------------
    // Distribution sync state machine
    // ----------------------------------------
    always_comb begin
        sync_d = sync_q;
        unique case (sync_q)
            // Held: wait for lock or override
            VCODIV_HELD: begin
                if (sync_ovr || i_output_pll_lock) begin
                    sync_d = VCODIV_RELEASED;
                end
            end
            // Released: back to hold once both are gone
            VCODIV_RELEASED: begin
                if (!sync_ovr && !i_output_pll_lock) begin
                    sync_d = VCODIV_HELD;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync_q <= VCODIV_HELD;
        end else begin
            sync_q <= sync_d;
        end
    end

    // Release pulse starts all dividers together
    // Fires in the cycle in which hold drops
    logic rel_pulse_q;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rel_pulse_q <= 1'b0;
        end else begin
            rel_pulse_q <= (sync_q == VCODIV_HELD) && (sync_d == VCODIV_RELEASED);
        end
    end
    // Hold level straight from the state register
    assign o_dist_sync_hold = (sync_q == VCODIV_HELD);
    assign o_dist_sync_release = rel_pulse_q;

    // ----------------------------------------
    // Oscillator controls
    // ----------------------------------------
    // Reference valid from indicator unless overridden
    assign o_output_pll_ref_valid = ref_ovr | i_input_pll_osc_valid;
    // Midscale force straight from its bit
    assign o_osc_midscale = ctrl_q[MIDSCALE_BIT];
    // Calibration runs while the bit is one
    assign o_osc_cal_run = cal_bit;
    // Calibration held in reset while the bit is zero
    assign o_osc_cal_reset = ~cal_bit;

    // ----------------------------------------
    // Divider controls
    // ----------------------------------------
    // Power-down levels of both dividers
    assign o_first_osc_divider_pd = div_q[DIV1_PD_BIT];
    assign o_second_osc_divider_pd = div_q[DIV2_PD_BIT];
    // Ratio decode of each field
    assign o_first_osc_divider_ratio = ratio_of(div_q[DIV1_LSB +: 2]);
    assign o_second_osc_divider_ratio = ratio_of(div_q[DIV2_LSB +: 2]);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Hold falls from one cycle to the next
    sequence s_release;
        o_dist_sync_hold ##1 !o_dist_sync_hold;
    endsequence

    // Held with lock present
    sequence s_held_locked;
        o_dist_sync_hold && i_output_pll_lock;
    endsequence

    // Held with the release override set
    sequence s_held_forced;
        o_dist_sync_hold && sync_ovr;
    endsequence

    // Released and start pulse in one cycle
    sequence s_started;
        !o_dist_sync_hold && o_dist_sync_release;
    endsequence

    chk_hold_until_lock: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!sync_ovr && !i_output_pll_lock) |=> o_dist_sync_hold)
        else $error("distribution released without lock or override");

    chk_lock_releases: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_release |-> o_dist_sync_release)
        else $error("release pulse missing");

    chk_override_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        sync_ovr |=> !o_dist_sync_hold)
        else $error("override did not release distribution");

    chk_ref_from_input: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !ref_ovr |-> (o_output_pll_ref_valid == i_input_pll_osc_valid))
        else $error("reference valid not from input pll");

    chk_ref_forced: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        ctrl_q[REF_OVR_BIT] |-> o_output_pll_ref_valid)
        else $error("reference override ignored");

    chk_midscale_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_wr && hit_ctrl) |=> (o_osc_midscale == $past(i_wdata[MIDSCALE_BIT])))
        else $error("midscale does not follow write");

    chk_cal_sticky: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_osc_cal_run && !(i_wr && hit_ctrl)) |=> o_osc_cal_run)
        else $error("calibrate bit cleared by hardware");

    chk_cal_reset: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_wr && hit_ctrl && !i_wdata[CAL_BIT]) |=> o_osc_cal_reset)
        else $error("calibration not held in reset");

    chk_div_pd: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_wr && hit_div) |=> (o_second_osc_divider_pd == $past(i_wdata[DIV2_PD_BIT]))
            && (o_first_osc_divider_pd == $past(i_wdata[DIV1_PD_BIT])))
        else $error("divider power-down mismatch");

    chk_div2_ratio: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_div && i_wdata[DIV2_LSB +: 2] == DIVSEL_3_ALT) |=> (o_second_osc_divider_ratio == RATIO_3))
        else $error("second divider code 11 not divide by 3");

    chk_div1_ratio: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_div && i_wdata[DIV1_LSB +: 2] == DIVSEL_5) |=> (o_first_osc_divider_ratio == RATIO_5))
        else $error("first divider code 10 not divide by 5");

    // Hold and start pulse never overlap
    chk_held_no_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_dist_sync_hold |-> !o_dist_sync_release)
        else $error("release pulse while distribution held");

    // Lock seen while held starts every divider on the next edge
    chk_lock_starts: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_held_locked |=> s_started)
        else $error("lock did not start the dividers");

    // Start pulse lasts one cycle only
    chk_pulse_single: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_dist_sync_release |=> !o_dist_sync_release)
        else $error("release pulse longer than one cycle");

    // Override seen while held starts every divider on the next edge
    chk_override_starts: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_held_forced |=> s_started)
        else $error("override did not start the dividers");

    // Released state kept while lock or override stays
    chk_release_kept: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!o_dist_sync_hold && (sync_ovr || i_output_pll_lock)) |=> !o_dist_sync_hold)
        else $error("distribution held again with lock or override present");

    // No indicator and no override means no valid reference
    chk_ref_absent: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!ref_ovr && !i_input_pll_osc_valid) |-> !o_output_pll_ref_valid)
        else $error("reference valid without indicator or override");

    // Override wins against an invalid indicator
    chk_ref_overrides: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ref_ovr && !i_input_pll_osc_valid) |-> o_output_pll_ref_valid)
        else $error("override lost against invalid indicator");

    // Midscale changes only by a control write
    chk_midscale_kept: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !wr_ctrl |=> $stable(o_osc_midscale))
        else $error("midscale changed without a write");

    // Writing one starts calibration on the next cycle
    chk_cal_start: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_ctrl && i_wdata[CAL_BIT]) |=> (o_osc_cal_run && !o_osc_cal_reset))
        else $error("calibration did not start");

    // Calibration reset stays until software writes one
    chk_cal_held: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_osc_cal_reset && !wr_ctrl) |=> o_osc_cal_reset)
        else $error("calibration left reset without a write");

    // Power-downs change only by a divider write
    chk_pd_kept: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !wr_div |=> ($stable(o_first_osc_divider_pd) && $stable(o_second_osc_divider_pd)))
        else $error("divider power-down changed without a write");

    // Second divider code 01 divides by four
    chk_div2_four: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_div && i_wdata[DIV2_LSB +: 2] == DIVSEL_4) |=> (o_second_osc_divider_ratio == RATIO_4))
        else $error("second divider code 01 not divide by 4");

    // Second divider code 10 divides by five
    chk_div2_five: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_div && i_wdata[DIV2_LSB +: 2] == DIVSEL_5) |=> (o_second_osc_divider_ratio == RATIO_5))
        else $error("second divider code 10 not divide by 5");

    // First divider code 00 divides by three
    chk_div1_three: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_div && i_wdata[DIV1_LSB +: 2] == DIVSEL_3) |=> (o_first_osc_divider_ratio == RATIO_3))
        else $error("first divider code 00 not divide by 3");

    // First divider code 01 divides by four
    chk_div1_four: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_div && i_wdata[DIV1_LSB +: 2] == DIVSEL_4) |=> (o_first_osc_divider_ratio == RATIO_4))
        else $error("first divider code 01 not divide by 4");

endmodule : vcodiv_top
`default_nettype wire

// ---- test/tb_top.sv ----
// Testbench: register access, sync release, reference valid and divider selection
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import vcodiv_pkg::*;
    // ----------------------------------------
    // Stimulus, observed outputs and counters
    // ----------------------------------------
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_output_pll_lock = 1'b0;
    logic i_input_pll_osc_valid = 1'b0;
    logic [7:0] o_rdata;
    logic o_dist_sync_hold, o_dist_sync_release, o_output_pll_ref_valid;
    logic o_osc_midscale, o_osc_cal_run, o_osc_cal_reset;
    logic o_first_osc_divider_pd, o_second_osc_divider_pd;
    logic [2:0] o_first_osc_divider_ratio, o_second_osc_divider_ratio;
    int failures = 0;
    int checks = 0;
    vcodiv_top vcodiv_top_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_output_pll_lock(i_output_pll_lock), .i_input_pll_osc_valid(i_input_pll_osc_valid),
        .o_dist_sync_hold(o_dist_sync_hold), .o_dist_sync_release(o_dist_sync_release),
        .o_output_pll_ref_valid(o_output_pll_ref_valid), .o_osc_midscale(o_osc_midscale),
        .o_osc_cal_run(o_osc_cal_run), .o_osc_cal_reset(o_osc_cal_reset),
        .o_first_osc_divider_pd(o_first_osc_divider_pd),
        .o_first_osc_divider_ratio(o_first_osc_divider_ratio),
        .o_second_osc_divider_pd(o_second_osc_divider_pd),
        .o_second_osc_divider_ratio(o_second_osc_divider_ratio));
    // 100 ns clock
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Compare and count
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // One-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
        @(posedge i_clk);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(name, o_rdata, exp);
    endtask : rd
    // Watch five cycles: exactly one release pulse, hold ends low
    task automatic watch_release();
        int pulses;
        pulses = 0;
        for (int n = 0; n < 5; n++) begin
            @(posedge i_clk);
            #1 if (o_dist_sync_release === 1'b1) pulses++;
        end
        chk("release pulses", 8'(pulses), 8'h01);
        chk("hold after release", {7'h00, o_dist_sync_hold}, 8'h00);
    endtask : watch_release
    // Expected ratio of a divider code
    function automatic logic [2:0] ratio_of(input logic [1:0] c);
        return (c == 2'h1) ? RATIO_4 : (c == 2'h2) ? RATIO_5 : RATIO_3;
    endfunction : ratio_of
    // Verdict
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset values seen on outputs and registers
    task automatic t_reset();
        #1 chk("cal reset value", {6'h00, o_osc_cal_run, o_osc_cal_reset}, 8'h01);
        chk("hold reset value", {7'h00, o_dist_sync_hold}, 8'h01);
        chk("ratio reset", {2'h0, o_second_osc_divider_ratio, o_first_osc_divider_ratio}, {2'h0, RATIO_3, RATIO_3});
        rd(OSC_CTRL_ADDR, OSC_CTRL_RESET, "ctrl reset");
        rd(OSC_DIV_ADDR, OSC_DIV_RESET, "div reset");
        $display("test reset done");
    endtask : t_reset
    // Held until lock, release on lock, held again on loss, then override
    task automatic t_sync();
        repeat (6) @(posedge i_clk);
        #1 chk("hold unlocked", {7'h00, o_dist_sync_hold}, 8'h01);
        @(posedge i_clk);
        i_output_pll_lock <= 1'b1;
        watch_release();
        @(posedge i_clk);
        i_output_pll_lock <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1 chk("hold relost", {7'h00, o_dist_sync_hold}, 8'h01);
        wr(OSC_CTRL_ADDR, 8'h10);
        watch_release();
        wr(OSC_CTRL_ADDR, 8'h00);
        $display("test sync done");
    endtask : t_sync
    // Reference valid from indicator or override
    task automatic t_ref();
        @(posedge i_clk);
        #1 chk("ref invalid", {7'h00, o_output_pll_ref_valid}, 8'h00);
        @(posedge i_clk);
        i_input_pll_osc_valid <= 1'b1;
        #1 chk("ref valid", {7'h00, o_output_pll_ref_valid}, 8'h01);
        @(posedge i_clk);
        i_input_pll_osc_valid <= 1'b0;
        wr(OSC_CTRL_ADDR, 8'h08);
        @(posedge i_clk);
        #1 chk("ref forced", {7'h00, o_output_pll_ref_valid}, 8'h01);
        rd(OSC_CTRL_ADDR, 8'h08, "ctrl ref");
        $display("test ref done");
    endtask : t_ref
    // Midscale, calibration start, no self clear, rerun by zero then one
    task automatic t_cal();
        wr(OSC_CTRL_ADDR, 8'hE5);
        @(posedge i_clk);
        #1 chk("midscale", {6'h00, o_osc_midscale, o_osc_cal_reset}, 8'h03);
        rd(OSC_CTRL_ADDR, 8'h04, "ctrl reserved");
        wr(OSC_CTRL_ADDR, 8'h02);
        repeat (20) @(posedge i_clk);
        #1 chk("cal run", {5'h00, o_osc_midscale, o_osc_cal_run, o_osc_cal_reset}, 8'h02);
        rd(OSC_CTRL_ADDR, 8'h02, "cal kept");
        wr(OSC_CTRL_ADDR, 8'h00);
        @(posedge i_clk);
        #1 chk("cal reset", {6'h00, o_osc_cal_run, o_osc_cal_reset}, 8'h01);
        wr(OSC_CTRL_ADDR, 8'h02);
        @(posedge i_clk);
        #1 chk("cal rerun", {6'h00, o_osc_cal_run, o_osc_cal_reset}, 8'h02);
        $display("test cal done");
    endtask : t_cal
    // Every ratio code of both dividers, power-downs, reserved and unmapped places
    task automatic t_div();
        logic [1:0] c;
        for (int n = 0; n < 4; n++) begin
            c = 2'(n);
            wr(OSC_DIV_ADDR, {1'b1, c[0], c, 1'b1, ~c[0], ~c});
            @(posedge i_clk);
            #1 chk("div2 ratio", {5'h00, o_second_osc_divider_ratio}, {5'h00, ratio_of(c)});
            chk("div1 ratio", {5'h00, o_first_osc_divider_ratio}, {5'h00, ratio_of(~c)});
            chk("div pd", {6'h00, o_second_osc_divider_pd, o_first_osc_divider_pd}, {6'h00, c[0], ~c[0]});
            rd(OSC_DIV_ADDR, {1'b0, c[0], c, 1'b0, ~c[0], ~c}, "div readback");
        end
        wr(12'h0F5, 8'hFF);
        rd(12'h0F5, UNMAPPED_DATA, "unmapped");
        rd(OSC_DIV_ADDR, 8'h70, "div untouched");
        $display("test div done");
    endtask : t_div
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_reset();
        t_sync();
        t_ref();
        t_cal();
        t_div();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
